// file: design/aic_regs.vh
// Purpose: register addresses, reset values and field positions of the analog input conditioning block
// Assumes: included by every design file of the block
// Notes:   definitions only
`ifndef AIC_REGS_VH
`define AIC_REGS_VH

`define AIC_ADDR_RAW        6'h00
`define AIC_ADDR_DIAG       6'h06
`define AIC_ADDR_HWREV      6'h10
`define AIC_ADDR_HWOFS      6'h11
`define AIC_ADDR_HWGAIN     6'h12
`define AIC_ADDR_MFOFS      6'h13
`define AIC_ADDR_MFSCALE    6'h14
`define AIC_ADDR_UPLIM      6'h15
`define AIC_ADDR_LOLIM      6'h16
`define AIC_ADDR_ADCPRE     6'h17
`define AIC_ADDR_CODE       6'h1F
`define AIC_ADDR_FEAT       6'h20
`define AIC_ADDR_USOFS      6'h21
`define AIC_ADDR_USSCALE    6'h22
`define AIC_ADDR_LIM1       6'h23
`define AIC_ADDR_LIM2       6'h24

`define AIC_RST_HWOFS       16'h0000
`define AIC_RST_HWGAIN      16'h1000
`define AIC_RST_MFOFS       16'h0000
`define AIC_RST_MFSCALE     16'h2002
`define AIC_RST_UPLIM       16'h0FFF
`define AIC_RST_LOLIM       16'h0000
`define AIC_RST_ADCPRE      16'h1000
`define AIC_RST_FEAT        16'h1106
`define AIC_RST_USOFS       16'h0000
`define AIC_RST_USSCALE     16'h0100
`define AIC_RST_ZERO        16'h0000
`define AIC_CODE_WORD       16'h1235

`define AIC_FB_USER         0
`define AIC_FB_MFR          1
`define AIC_FB_WDOG         2
`define AIC_FB_SIGNMAG      3
`define AIC_FB_PACKED       4
`define AIC_FB_RANGE        8
`define AIC_FB_LIM1         9
`define AIC_FB_LIM2         10
`define AIC_FB_FILT         11

`define AIC_CB_REG          7
`define AIC_CB_WR           6

`define AIC_SHIFT_HW        12
`define AIC_SHIFT_MFR       10
`define AIC_SHIFT_USER      8

`define AIC_ST_ERR          6
`define AIC_ST_OVR          1
`define AIC_ST_UNR          0

`define AIC_CMP_OFF         2'h0
`define AIC_CMP_BELOW       2'h1
`define AIC_CMP_ABOVE       2'h2
`define AIC_CMP_EQUAL       2'h3

`define AIC_PACK_LSB        3
`define AIC_TEN_VOLT        16'h0FFF

`endif

// file: design/aic_limit_cmp.v
// Purpose: compare one value against one limit and give a two-bit code
// Assumes: signed 16-bit operands
// Notes:   used once per limit per channel
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.vh"

module aic_limit_cmp (
  input  wire        enable_in,
  input  wire [15:0] value_in,
  input  wire [15:0] limit_in,
  output reg  [1:0]  code_out
);

  always @* begin
    if (!enable_in)
      code_out = `AIC_CMP_OFF;
    else if ($signed(value_in) < $signed(limit_in))
      code_out = `AIC_CMP_BELOW;
    else if ($signed(value_in) > $signed(limit_in))
      code_out = `AIC_CMP_ABOVE;
    else
      code_out = `AIC_CMP_EQUAL;
  end

endmodule // aic_limit_cmp
`default_nettype wire

// file: design/aic_channel.v
// Purpose: register set and process-data conditioning of one analog input channel
// Assumes: register access by control byte and data word, one access per strobe
// Notes:   one instance per channel; conversion samples arrive as a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.vh"

module aic_channel #(
  parameter [15:0] HW_REVISION = 16'h0001,  // arbitrary value
  parameter        WDOG_CYCLES = 2500000    // 100 ms at 25 MHz
) (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        acc_strobe_in,
  input  wire [7:0]  ctrl_byte_in,
  input  wire [15:0] wr_data_in,
  input  wire        sample_valid_in,
  input  wire [15:0] sample_in,
  input  wire        error_in,
  input  wire        bus_activity_in,
  output reg  [7:0]  status_byte_out,
  output reg  [15:0] rd_data_out,
  output reg  [15:0] process_data_out,
  output reg         process_valid_out,
  output reg  [15:0] adc_offset_out,
  output reg         wdog_expired_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] raw_reg;
  reg [15:0] hw_ofs_reg;
  reg [15:0] hw_gain_reg;
  reg [15:0] mf_ofs_reg;
  reg [15:0] mf_scale_reg;
  reg [15:0] up_lim_reg;
  reg [15:0] lo_lim_reg;
  reg [15:0] adc_pre_reg;
  reg [15:0] code_reg;
  reg [15:0] feat_reg;
  reg [15:0] us_ofs_reg;
  reg [15:0] us_scale_reg;
  reg [15:0] lim1_reg;
  reg [15:0] lim2_reg;
  reg        ovr_reg;
  reg        unr_reg;
  reg [1:0]  cmp1_reg;
  reg [1:0]  cmp2_reg;
  reg [15:0] tap1_reg;
  reg [15:0] tap2_reg;
  reg [31:0] wdog_reg;

  wire [5:0] addr       = ctrl_byte_in[5:0];
  wire       reg_mode   = acc_strobe_in & ctrl_byte_in[`AIC_CB_REG];
  wire       write_not_read_flag = ctrl_byte_in[`AIC_CB_WR];
  wire       wr_en      = reg_mode & write_not_read_flag;
  wire       unlocked   = (code_reg == `AIC_CODE_WORD);
  wire       prot_wr    = wr_en & unlocked;

  // ----------------------------------------------------------------
  // conditioning path
  // ----------------------------------------------------------------
  reg signed [31:0] s_hw;
  reg signed [31:0] s_mf;
  reg signed [31:0] s_us;
  reg signed [15:0] s_sat;
  reg signed [15:0] s_lim;
  reg signed [17:0] s_fir;
  reg signed [15:0] s_out;
  reg signed [15:0] s_mag;
  reg               over_ten;
  reg               ovr_next;
  reg               unr_next;
  reg        [15:0] fmt_next;

  // saturate a wide signed value into 16 bits
  function signed [15:0] sat16;
    input signed [31:0] v;
    begin
      if (v > 32'sd32767)
        sat16 = 16'sh7FFF;
      else if (v < -32'sd32768)
        sat16 = 16'sh8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  always @* begin
    s_hw = (($signed(sample_in) * $signed(hw_gain_reg)) >>> `AIC_SHIFT_HW) + $signed(hw_ofs_reg);
    if (feat_reg[`AIC_FB_MFR])
      s_mf = (($signed(sat16(s_hw)) * $signed(mf_scale_reg)) >>> `AIC_SHIFT_MFR) + $signed(mf_ofs_reg);
    else
      s_mf = s_hw;
    if (feat_reg[`AIC_FB_USER])
      s_us = (($signed(sat16(s_mf)) * $signed(us_scale_reg)) >>> `AIC_SHIFT_USER) + $signed(us_ofs_reg);
    else
      s_us = s_mf;
    s_sat    = sat16(s_us);
    s_lim    = s_sat;
    ovr_next = 1'b0;
    unr_next = 1'b0;
    if (feat_reg[`AIC_FB_RANGE]) begin
      if (s_sat > $signed(up_lim_reg)) begin
        ovr_next = 1'b1;
        s_lim    = $signed(up_lim_reg);
      end
      if (s_sat < $signed(lo_lim_reg)) begin
        unr_next = 1'b1;
        s_lim    = $signed(lo_lim_reg);
      end
    end
    s_fir = ({{2{s_lim[15]}}, s_lim} + {{1{tap1_reg[15]}}, tap1_reg, 1'b0}
            + {{2{tap2_reg[15]}}, tap2_reg}) >>> 2;
    s_out = feat_reg[`AIC_FB_FILT] ? s_fir[15:0] : s_lim;
    fmt_next = s_out;
    s_mag    = -s_out;
    // saturate first so a wrapped hw result cannot hide an overflow
    over_ten = (sat16(s_hw) > $signed(`AIC_TEN_VOLT));
    if (feat_reg[`AIC_FB_SIGNMAG] && s_out[15])
      fmt_next = {1'b1, s_mag[14:0]};
    // packed status format
    // low bits are overwritten; the user stage must scale to free them
    if (feat_reg[`AIC_FB_PACKED])
      fmt_next = {fmt_next[15:`AIC_PACK_LSB], 1'b0, error_in, over_ten};
  end

  wire [1:0] cmp1_next;
  wire [1:0] cmp2_next;

  aic_limit_cmp u_cmp1 (
    .enable_in (feat_reg[`AIC_FB_LIM1]),
    .value_in  (s_out),
    .limit_in  (lim1_reg),
    .code_out  (cmp1_next)
  );

  aic_limit_cmp u_cmp2 (
    .enable_in (feat_reg[`AIC_FB_LIM2]),
    .value_in  (s_out),
    .limit_in  (lim2_reg),
    .code_out  (cmp2_next)
  );

  // ----------------------------------------------------------------
  // process status byte
  // ----------------------------------------------------------------
  // disabled compare reads off at once, not at the next sample
  wire [1:0] lim1_code = feat_reg[`AIC_FB_LIM1] ? cmp1_reg : `AIC_CMP_OFF;
  wire [1:0] lim2_code = feat_reg[`AIC_FB_LIM2] ? cmp2_reg : `AIC_CMP_OFF;
  wire [7:0] stat_proc = {1'b0, error_in, lim2_code[0], lim2_code[1], lim1_code[0], lim1_code[1], ovr_reg, unr_reg};

  // ----------------------------------------------------------------
  // sequential
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      raw_reg      <= `AIC_RST_ZERO;
      hw_ofs_reg   <= `AIC_RST_HWOFS;
      hw_gain_reg  <= `AIC_RST_HWGAIN;
      mf_ofs_reg   <= `AIC_RST_MFOFS;
      mf_scale_reg <= `AIC_RST_MFSCALE;
      up_lim_reg   <= `AIC_RST_UPLIM;
      lo_lim_reg   <= `AIC_RST_LOLIM;
      adc_pre_reg  <= `AIC_RST_ADCPRE;
      code_reg     <= `AIC_RST_ZERO;
      feat_reg     <= `AIC_RST_FEAT;
      us_ofs_reg   <= `AIC_RST_USOFS;
      us_scale_reg <= `AIC_RST_USSCALE;
      lim1_reg     <= `AIC_RST_ZERO;
      lim2_reg     <= `AIC_RST_ZERO;
      ovr_reg      <= 1'b0;
      unr_reg      <= 1'b0;
      cmp1_reg     <= `AIC_CMP_OFF;
      cmp2_reg     <= `AIC_CMP_OFF;
      tap1_reg     <= `AIC_RST_ZERO;
      tap2_reg     <= `AIC_RST_ZERO;
      process_data_out  <= `AIC_RST_ZERO;
      process_valid_out <= 1'b0;
      rd_data_out       <= `AIC_RST_ZERO;
      status_byte_out   <= 8'h00;
      adc_offset_out    <= `AIC_RST_ADCPRE;
      wdog_reg          <= 32'h0;
      wdog_expired_out  <= 1'b0;
    end else begin
      process_valid_out <= sample_valid_in;
      // converter offset preset
      // registered copy: the converter sees a new preset one cycle after the write
      adc_offset_out <= adc_pre_reg;
      if (sample_valid_in) begin
        raw_reg          <= sample_in;
        process_data_out <= fmt_next;
        ovr_reg          <= ovr_next;
        unr_reg          <= unr_next;
        cmp1_reg         <= cmp1_next;
        cmp2_reg         <= cmp2_next;
        tap1_reg         <= s_lim;
        tap2_reg         <= tap1_reg;
      end
      if (wr_en && addr == `AIC_ADDR_CODE)
        code_reg <= wr_data_in;
      if (prot_wr) begin
        case (addr)
          `AIC_ADDR_HWOFS:   hw_ofs_reg   <= wr_data_in;
          `AIC_ADDR_HWGAIN:  hw_gain_reg  <= wr_data_in;
          `AIC_ADDR_MFOFS:   mf_ofs_reg   <= wr_data_in;
          `AIC_ADDR_MFSCALE: mf_scale_reg <= wr_data_in;
          `AIC_ADDR_UPLIM:   up_lim_reg   <= wr_data_in;
          `AIC_ADDR_LOLIM:   lo_lim_reg   <= wr_data_in;
          `AIC_ADDR_ADCPRE:  adc_pre_reg  <= wr_data_in;
          `AIC_ADDR_FEAT:    feat_reg     <= wr_data_in;
          `AIC_ADDR_USOFS:   us_ofs_reg   <= wr_data_in;
          `AIC_ADDR_USSCALE: us_scale_reg <= wr_data_in;
          `AIC_ADDR_LIM1:    lim1_reg     <= wr_data_in;
          `AIC_ADDR_LIM2:    lim2_reg     <= wr_data_in;
          default: ;
        endcase
      end
      if (reg_mode) begin
        status_byte_out <= ctrl_byte_in;
        if (write_not_read_flag)
          rd_data_out <= `AIC_RST_ZERO;
        else begin
          case (addr)
            `AIC_ADDR_RAW:     rd_data_out <= raw_reg;
            `AIC_ADDR_DIAG:    rd_data_out <= {8'h00, stat_proc};
            `AIC_ADDR_HWREV:   rd_data_out <= HW_REVISION;
            `AIC_ADDR_HWOFS:   rd_data_out <= hw_ofs_reg;
            `AIC_ADDR_HWGAIN:  rd_data_out <= hw_gain_reg;
            `AIC_ADDR_MFOFS:   rd_data_out <= mf_ofs_reg;
            `AIC_ADDR_MFSCALE: rd_data_out <= mf_scale_reg;
            `AIC_ADDR_UPLIM:   rd_data_out <= up_lim_reg;
            `AIC_ADDR_LOLIM:   rd_data_out <= lo_lim_reg;
            `AIC_ADDR_ADCPRE:  rd_data_out <= adc_pre_reg;
            `AIC_ADDR_CODE:    rd_data_out <= unlocked ? code_reg : `AIC_RST_ZERO;
            `AIC_ADDR_FEAT:    rd_data_out <= feat_reg;
            `AIC_ADDR_USOFS:   rd_data_out <= us_ofs_reg;
            `AIC_ADDR_USSCALE: rd_data_out <= us_scale_reg;
            `AIC_ADDR_LIM1:    rd_data_out <= lim1_reg;
            `AIC_ADDR_LIM2:    rd_data_out <= lim2_reg;
            default:           rd_data_out <= `AIC_RST_ZERO;
          endcase
        end
      end else if (acc_strobe_in) begin
        status_byte_out <= stat_proc;
      end
      // watchdog: no bus traffic for the timeout raises expiry
      if (!feat_reg[`AIC_FB_WDOG] || bus_activity_in) begin
        wdog_reg         <= 32'h0;
        wdog_expired_out <= 1'b0;
      end else if (wdog_reg == WDOG_CYCLES - 1)
        wdog_expired_out <= 1'b1;
      else
        wdog_reg <= wdog_reg + 32'h1;
    end
  end

endmodule // aic_channel
`default_nettype wire

// file: tb/aic_channel_assertions.sv
// Purpose: concurrent checks on the ports of one conditioning channel
// Assumes: sync active-high reset, one register access per strobe
// Notes:   feature and unlock state are shadowed from observed writes
`timescale 1ns/1ps
`default_nettype none
module aic_channel_assertions #(
  parameter [15:0] HW_REVISION = 16'h00A5,
  parameter        WDOG_CYCLES = 16
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        acc_strobe_in,
  input wire logic [7:0]  ctrl_byte_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        sample_valid_in,
  input wire logic [15:0] sample_in,
  input wire logic        error_in,
  input wire logic        bus_activity_in,
  input wire logic [7:0]  status_byte_out,
  input wire logic [15:0] rd_data_out,
  input wire logic [15:0] process_data_out,
  input wire logic        process_valid_out,
  input wire logic [15:0] adc_offset_out,
  input wire logic        wdog_expired_out
);
  // ----------------------------------------
  // shadow state and properties
  // ----------------------------------------
  logic        unlock_reg;
  logic [15:0] feat_reg;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      unlock_reg <= 1'b0;
      feat_reg   <= 16'h1106;
    end else if (acc_strobe_in && ctrl_byte_in == 8'hDF) begin
      unlock_reg <= (wr_data_in == 16'h1235);
    end else if (acc_strobe_in && ctrl_byte_in == 8'hE0 && unlock_reg) begin
      feat_reg <= wr_data_in;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_reg_access; acc_strobe_in && ctrl_byte_in[7]; endsequence
  sequence s_reg_write; acc_strobe_in && ctrl_byte_in[7:6] == 2'b11; endsequence
  sequence s_one_sample; sample_valid_in ##1 !sample_valid_in; endsequence
  property p_echo; s_reg_access |=> status_byte_out == $past(ctrl_byte_in); endproperty
  a_echo: assert property (p_echo) else $error("status byte does not echo control byte");
  property p_wr_zero; s_reg_write |=> rd_data_out == 16'h0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero after write");
  property p_code_read;
    acc_strobe_in && ctrl_byte_in == 8'h9F |=> rd_data_out == (unlock_reg ? 16'h1235 : 16'h0000);
  endproperty
  a_code_read: assert property (p_code_read) else $error("code word readback wrong");
  property p_feat_read; acc_strobe_in && ctrl_byte_in == 8'hA0 |=> rd_data_out == feat_reg; endproperty
  a_feat_read: assert property (p_feat_read) else $error("feature readback wrong");
  property p_one_sample; s_one_sample |-> process_valid_out ##1 !process_valid_out; endproperty
  a_one_sample: assert property (p_one_sample) else $error("process valid pulse wrong");
  property p_packed_low;
    process_valid_out && feat_reg[4] |-> process_data_out[2:1] == {1'b0, $past(error_in)};
  endproperty
  a_packed_low: assert property (p_packed_low) else $error("packed status bits wrong");
  property p_lim1_off;
    acc_strobe_in && !ctrl_byte_in[7] && !feat_reg[9] |=> status_byte_out[3:2] == 2'b00;
  endproperty
  a_lim1_off: assert property (p_lim1_off) else $error("limit 1 code while disabled");
  property p_lim2_off;
    acc_strobe_in && !ctrl_byte_in[7] && !feat_reg[10] |=> status_byte_out[5:4] == 2'b00;
  endproperty
  a_lim2_off: assert property (p_lim2_off) else $error("limit 2 code while disabled");
  property p_adc_hold;
    !$past(acc_strobe_in && ctrl_byte_in == 8'hD7) |=> $stable(adc_offset_out);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("converter preset changed without write");
endmodule // aic_channel_assertions
bind aic_channel aic_channel_assertions #(.HW_REVISION(HW_REVISION), .WDOG_CYCLES(WDOG_CYCLES)) u_aic_chk (
  .clk_in, .sys_rst_in, .acc_strobe_in, .ctrl_byte_in, .wr_data_in, .sample_valid_in, .sample_in,
  .error_in, .bus_activity_in, .status_byte_out, .rd_data_out, .process_data_out, .process_valid_out,
  .adc_offset_out, .wdog_expired_out);
`default_nettype wire

// file: tb/aic_coupler_model.sv
// Purpose: controller behind the coupler issuing control-byte register accesses
// Assumes: one access per call, strobe held for exactly one sampling edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module aic_coupler_model (
  input  wire logic        clk_in,
  output var  logic        acc_strobe_out,
  output var  logic [7:0]  ctrl_byte_out,
  output var  logic [15:0] wr_data_out
);
  // ----------------------------------------
  // access task
  // ----------------------------------------
  initial begin
    acc_strobe_out = 1'b0;
    ctrl_byte_out  = 8'h00;
    wr_data_out    = 16'h0000;
  end
  task automatic access(input logic [7:0] ctrl, input logic [15:0] data);
    @(posedge clk_in);
    acc_strobe_out <= 1'b1;
    ctrl_byte_out  <= ctrl;
    wr_data_out    <= data;
    @(posedge clk_in);
    acc_strobe_out <= 1'b0;
    ctrl_byte_out  <= ~ctrl;
    wr_data_out    <= ~data;
    #1;
  endtask
endmodule // aic_coupler_model
`default_nettype wire

// file: tb/aic_channel_tb_top.sv
// Purpose: self-checking bench for one conditioning channel
// Assumes: watchdog shortened to 16 cycles, answers one cycle after the strobe
// Notes:   rows are {kind, ctrl, data, expected word, expected status}
`timescale 1ns/1ps
`default_nettype none
module aic_channel_tb_top;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        sample_valid_in = 1'b0;
  logic        error_in = 1'b0;
  logic        bus_activity_in = 1'b1;
  logic [15:0] sample_in = 16'h0000;
  wire         acc_strobe_in, process_valid_out, wdog_expired_out;
  wire  [7:0]  ctrl_byte_in, status_byte_out;
  wire  [15:0] wr_data_in, rd_data_out, process_data_out, adc_offset_out;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [51:0] row_tab [0:35];
  aic_channel #(.HW_REVISION(16'h00A5), .WDOG_CYCLES(16)) u_aic_channel (
    .clk_in, .sys_rst_in, .acc_strobe_in, .ctrl_byte_in, .wr_data_in, .sample_valid_in, .sample_in,
    .error_in, .bus_activity_in, .status_byte_out, .rd_data_out, .process_data_out, .process_valid_out,
    .adc_offset_out, .wdog_expired_out);
  aic_coupler_model u_aic_coupler_model (.clk_in, .acc_strobe_out(acc_strobe_in),
    .ctrl_byte_out(ctrl_byte_in), .wr_data_out(wr_data_in));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put_sample(input logic [15:0] v);
    @(posedge clk_in);
    sample_valid_in <= 1'b1;
    sample_in       <= v;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
    sample_in       <= ~v;
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    row_tab = '{52'h0_94_0000_2002_94, 52'h0_A0_0000_1106_A0, 52'h0_95_0000_0FFF_95, 52'h0_96_0000_0000_96,
      52'h0_97_0000_1000_97, 52'h0_93_0000_0000_93, 52'h0_90_0000_00A5_90, 52'h0_9F_0000_0000_9F,
      52'h0_E0_0000_0000_E0, 52'h0_A0_0000_1106_A0, 52'h1_00_0080_0400_00, 52'h1_00_0200_0FFF_02,
      52'h1_00_FFF0_0000_01, 52'h0_80_0000_FFF0_80, 52'h0_86_0000_0001_86, 52'h0_81_0000_0000_81,
      52'h0_DF_1235_0000_DF, 52'h0_9F_0000_1235_9F, 52'h0_E0_0000_0000_E0, 52'h0_A0_0000_0000_A0,
      52'h1_00_1234_1234_00, 52'h0_E0_0008_0000_E0, 52'h1_00_FFFF_8001_00, 52'h0_E0_0010_0000_E0,
      52'h1_00_0010_0010_00, 52'h0_E3_0050_0000_E3, 52'h0_E0_0200_0000_E0, 52'h1_00_0040_0040_08,
      52'h1_00_0060_0060_04, 52'h1_00_0050_0050_0C, 52'h0_E4_0050_0000_E4, 52'h0_E0_0400_0000_E0,
      52'h1_00_0040_0040_20, 52'h0_E0_0000_0000_E0, 52'h0_D2_2000_0000_D2, 52'h1_00_0100_0200_00};
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 36; i++) begin
      if (row_tab[i][48]) begin
        put_sample(row_tab[i][39:24]);
        chk_word(process_data_out, row_tab[i][23:8]);
        // status only follows the process flags after a process-mode strobe
        u_aic_coupler_model.access(row_tab[i][47:40], row_tab[i][39:24]);
      end else begin
        u_aic_coupler_model.access(row_tab[i][47:40], row_tab[i][39:24]);
        chk_word(rd_data_out, row_tab[i][23:8]);
      end
      chk_byte(status_byte_out, row_tab[i][7:0]);
    end
    u_aic_coupler_model.access(8'hD1, 16'hFFFF);
    put_sample(16'h0100);
    chk_word(process_data_out, 16'h01FF);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    u_aic_coupler_model.access(8'hA0, 16'h0000);
    chk_word(rd_data_out, 16'h1106);
    chk_word(adc_offset_out, 16'h1000);
    u_aic_coupler_model.access(8'hDF, 16'h1235);
    u_aic_coupler_model.access(8'hD7, 16'h0ABC);
    u_aic_coupler_model.access(8'hE0, 16'h0014);
    chk_word(adc_offset_out, 16'h0ABC);
    @(posedge clk_in);
    error_in <= 1'b1;
    put_sample(16'h2000);
    chk_word(process_data_out, 16'h2003);
    put_sample(16'h0010);
    chk_word(process_data_out, 16'h0012);
    u_aic_coupler_model.access(8'h00, 16'h0000);
    chk_byte(status_byte_out, 8'h40);
    u_aic_coupler_model.access(8'hE2, 16'h0800);
    u_aic_coupler_model.access(8'hE0, 16'h0015);
    put_sample(16'h0010);
    chk_word(process_data_out, 16'h0082);
    @(posedge clk_in);
    error_in <= 1'b0;
    u_aic_coupler_model.access(8'hE0, 16'h0804);
    repeat (3) put_sample(16'h0100);
    chk_word(process_data_out, 16'h0100);
    @(posedge clk_in);
    bus_activity_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    #1;
    chk_byte({7'h00, wdog_expired_out}, 8'h01);
    print_verdict();
  end
endmodule // aic_channel_tb_top
`default_nettype wire
